// >>> verilog/tz_timer.sv
// Eight-bit timer/counter with a prescaler shared with the watchdog.
`timescale 1ns/10ps
module tz_timer #(
    parameter int P_TMR_W = 8,
    parameter int P_PRE_W = 8
) (
    input  wire logic                      i_clk,
    input  wire logic                      i_rst,
    input  wire logic [tz_pkg::ADDR_W-1:0] i_addr,
    input  wire logic [tz_pkg::DATA_W-1:0] i_wdata,
    input  wire logic                      i_wr,
    input  wire logic                      i_rd,
    output logic      [tz_pkg::DATA_W-1:0] o_rdata,
    input  wire logic                      i_ext_clk,
    input  wire logic                      i_sleep,
    input  wire logic                      i_wdt_tick,
    input  wire logic                      i_wdt_clear,
    output logic                           o_wdt_post,
    output logic                           o_irq
);

    // The timer must fit the data port; the prescaler needs the top tap.
    if (P_TMR_W < 2 || P_TMR_W > tz_pkg::DATA_W) begin : g_bad_tmr
        $error("tz_timer: P_TMR_W must lie between 2 and the data width.");
    end
    if (P_PRE_W < (2 ** tz_pkg::RS_W)) begin : g_bad_pre
        $error("tz_timer: P_PRE_W too small for the largest ratio.");
    end

    // Phase of the current instruction cycle.
    tz_pkg::tz_phase_e phase_q;
    // One-cycle enables in phases two and four.
    logic q2_en;
    logic q4_en;

    // Configuration and control state written by software.
    logic [tz_pkg::DATA_W-1:0] opt_q;      // Option register image.
    logic                      ie_q;       // Overflow interrupt enable.
    logic                      flag_q;     // Sticky overflow flag.

    // Fields decoded from the option register.
    logic                      cs;         // Clock source: pin when set.
    logic                      se;         // Falling edge when set.
    logic                      prescaler_assign;        // Prescaler to watchdog when set.
    logic [tz_pkg::RS_W-1:0]   rs;         // Rate select field.

    // Register port decode.
    logic                      wr_tmr;
    logic                      wr_ictl;
    logic                      wr_opt;
    logic                      ictl_hit;
    logic [P_TMR_W-1:0]        wdata_tmr;  // Write data cut to timer width.

    // Counting path.
    logic                      ext_lvl;    // Pin, inverted for falling edges.
    logic                      ext_prev_q; // Pin level one cycle ago.
    logic                      ext_rise;   // Selected pin edge, one cycle.
    logic                      pre_en;     // Prescaler count enable.
    logic                      pre_clr;    // Prescaler clear.
    logic [P_PRE_W-1:0]        pre_cnt;    // Prescaler count.
    logic                      src_lvl;    // Level fed to Q2/Q4 sampling.
    logic                      samp2_q;    // Level sampled in phase two.
    logic                      samp4_q;    // Level sampled in phase four.
    logic                      tick_evt;   // Candidate increment.
    logic                      inc_go;     // Increment actually taken.
    logic [1:0]                inhib_q;    // Cycles still blocked.
    logic [P_TMR_W-1:0]        tmr_q;      // Timer register.
    logic                      ovf_set;    // Rollover in this cycle.

    // Watchdog postscaler path.
    logic                      wdt_tap;    // Selected watchdog tap bit.
    logic                      wdt_tap_q;  // Tap bit one cycle ago.
    logic                      wdt_post_q; // Postscaled watchdog tick.

    // Registered outputs and the combinational read mux.
    logic [tz_pkg::DATA_W-1:0] rdata_q;
    logic [tz_pkg::DATA_W-1:0] rd_d;
    logic                      irq_q;

    // Four phases per instruction cycle; the phase keeps running in
    // sleep because the watchdog side still needs its own clock.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            phase_q <= tz_pkg::TZ_Q1;
        end else begin
            unique case (phase_q)
                tz_pkg::TZ_Q1: phase_q <= tz_pkg::TZ_Q2;
                tz_pkg::TZ_Q2: phase_q <= tz_pkg::TZ_Q3;
                tz_pkg::TZ_Q3: phase_q <= tz_pkg::TZ_Q4;
                tz_pkg::TZ_Q4: phase_q <= tz_pkg::TZ_Q1;
            endcase
        end
    end

    assign q2_en = (phase_q == tz_pkg::TZ_Q2);
    assign q4_en = (phase_q == tz_pkg::TZ_Q4);

    // Address decode; the control register answers at two addresses.
    assign ictl_hit  = (i_addr == tz_pkg::ADDR_ICTL) ||
                       (i_addr == tz_pkg::ADDR_ICTL_HI);
    assign wr_tmr    = i_wr && (i_addr == tz_pkg::ADDR_TMR);
    assign wr_ictl   = i_wr && ictl_hit;
    assign wr_opt    = i_wr && (i_addr == tz_pkg::ADDR_OPT);
    assign wdata_tmr = i_wdata[P_TMR_W-1:0];

    // Option register; written at any time, no stop needed.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            opt_q <= tz_pkg::RST_OPT;
        end else if (wr_opt) begin
            opt_q <= i_wdata;
        end
    end

    assign cs  = opt_q[tz_pkg::OPT_CS_BIT];
    assign se  = opt_q[tz_pkg::OPT_SE_BIT];
    assign prescaler_assign = opt_q[tz_pkg::OPT_PSA_BIT];
    assign rs  = opt_q[tz_pkg::OPT_RS_LSB +: tz_pkg::RS_W];

    // Edge select: invert the pin so the chosen edge is a rise.
    assign ext_lvl = i_ext_clk ^ se;

    // Previous pin level for the prescaler's edge count; reset loads
    // the idle level of a low pin under the reset edge choice.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ext_prev_q <= tz_pkg::RST_OPT[tz_pkg::OPT_SE_BIT];
        end else begin
            ext_prev_q <= ext_lvl;
        end
    end

    assign ext_rise = ext_lvl & ~ext_prev_q;

    // Prescaler routing: the watchdog tick or the timer source. The
    // timer side halts in sleep; the watchdog side does not.
    always_comb begin
        if (prescaler_assign) begin
            pre_en  = i_wdt_tick;
            pre_clr = i_wdt_clear;
        end else begin
            pre_en  = ~i_sleep & (cs ? ext_rise : q4_en);
            pre_clr = wr_tmr;
        end
    end

    // The shared counter itself.
    tz_prescaler #(
        .P_W     (P_PRE_W)
    ) u_prescaler (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_clr   (pre_clr),
        .i_en    (pre_en),
        .o_count (pre_cnt)
    );

    // Timer-side output: bit rs toggles every 2^rs events, so it rises
    // once per 2^(rs+1), giving 1:2 for code 0 and 1:256 for 7.
    // With the prescaler elsewhere the pin passes straight.
    always_comb begin
        if (prescaler_assign) begin
            src_lvl = ext_lvl;
        end else begin
            src_lvl = pre_cnt[rs];
        end
    end

    // The prescaler output is sampled in phases two and four, so every
    // level of two core clocks or more is seen; a shorter one can be
    // missed. Reset loads the idle level, so no false edge follows.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            samp2_q <= tz_pkg::RST_OPT[tz_pkg::OPT_SE_BIT];
            samp4_q <= tz_pkg::RST_OPT[tz_pkg::OPT_SE_BIT];
        end else begin
            if (q2_en) begin
                samp2_q <= src_lvl;
            end
            if (q4_en) begin
                samp4_q <= src_lvl;
            end
        end
    end

    // Pin mode or a divided source counts sampled rises; undivided
    // timer mode counts every phase four.
    assign tick_evt = (cs | ~prescaler_assign) ?
                      (q4_en & (samp2_q ? ~samp4_q : src_lvl)) : q4_en;

    // No increment in sleep, while blocked, or in a write cycle.
    assign inc_go = tick_evt & ~i_sleep & (inhib_q == 2'h0) & ~wr_tmr;

    // Block counter: a write skips the next two phase-four edges, so
    // software that wants exact time must add two to what it writes.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            inhib_q <= 2'h0;
        end else if (wr_tmr) begin
            inhib_q <= tz_pkg::INHIB_CYC;
        end else if (q4_en && inhib_q != 2'h0) begin
            inhib_q <= inhib_q - 2'h1;
        end
    end

    // Timer register: a write wins over an increment.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            tmr_q <= tz_pkg::RST_TMR[P_TMR_W-1:0];
        end else if (wr_tmr) begin
            tmr_q <= wdata_tmr;
        end else if (inc_go) begin
            tmr_q <= tmr_q + 1'b1;
        end
    end

    // Rollover from all ones to zero.
    assign ovf_set = inc_go & (&tmr_q);

    // Sticky flag, cleared by writing one; a rollover in the clearing
    // cycle wins so no overflow is lost. Only software clears it.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            flag_q <= 1'b0;
        end else if (ovf_set) begin
            flag_q <= 1'b1;
        end else if (wr_ictl && i_wdata[tz_pkg::ICTL_IF_BIT]) begin
            flag_q <= 1'b0;
        end
    end

    // Interrupt enable, the mask for the flag.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ie_q <= 1'b0;
        end else if (wr_ictl) begin
            ie_q <= i_wdata[tz_pkg::ICTL_IE_BIT];
        end
    end

    // Level interrupt, one cycle behind flag and enable.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= flag_q & ie_q;
        end
    end

    // Watchdog tap: code 0 passes the tick, code n uses bit n-1,
    // giving 1:1 up to 1:128.
    assign wdt_tap = (rs == '0) ? 1'b0 : pre_cnt[rs - 3'h1];

    // Postscaled tick; a change of assignment may cost or add one
    // tick, which is why software follows a safe switch order.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            wdt_tap_q  <= 1'b0;
            wdt_post_q <= 1'b0;
        end else begin
            wdt_tap_q <= wdt_tap;
            if (!prescaler_assign || i_wdt_clear) begin
                wdt_post_q <= 1'b0;
            end else if (rs == '0) begin
                wdt_post_q <= i_wdt_tick;
            end else begin
                wdt_post_q <= wdt_tap & ~wdt_tap_q;
            end
        end
    end

    // Read mux; the prescaler has no address and reads nowhere.
    always_comb begin
        rd_d = '0;
        if (i_addr == tz_pkg::ADDR_TMR) begin
            rd_d[P_TMR_W-1:0] = tmr_q;
        end else if (ictl_hit) begin
            rd_d[tz_pkg::ICTL_IE_BIT] = ie_q;
            rd_d[tz_pkg::ICTL_IF_BIT] = flag_q;
        end else if (i_addr == tz_pkg::ADDR_OPT) begin
            rd_d = opt_q;
        end
    end

    // Read data stand only in the cycle after the read strobe.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            rdata_q <= tz_pkg::RST_RD;
        end else if (i_rd) begin
            rdata_q <= rd_d;
        end else begin
            rdata_q <= tz_pkg::RST_RD;
        end
    end

    // Outputs leave straight from flip-flops.
    assign o_rdata    = rdata_q;
    assign o_irq      = irq_q;
    assign o_wdt_post = wdt_post_q;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    // A timer write followed by quiet bus cycles.
    sequence s_tmr_write;
        wr_tmr;
    endsequence
    sequence s_bus_quiet;
        (!i_wr) [*7];
    endsequence

    // Undivided timer mode counts one per instruction cycle.
    timer_step_a: assert property (
        !cs && prescaler_assign && q4_en && inhib_q == 2'h0 && !i_sleep && !wr_tmr
        |=> tmr_q == P_TMR_W'($past(tmr_q) + 1'b1))
        else $error("Timer did not step in timer mode.");

    // The written value holds across the two blocked cycles.
    write_block_a: assert property (
        s_tmr_write ##1 s_bus_quiet |-> tmr_q == $past(wdata_tmr, 7))
        else $error("Timer moved inside the write block window.");

    // A sampled pin rise counts once in counter mode.
    pin_edge_a: assert property (
        cs && prescaler_assign && q4_en && (samp2_q ? !samp4_q : ext_lvl)
        && inhib_q == 2'h0
        && !i_sleep && !wr_tmr |=> tmr_q == P_TMR_W'($past(tmr_q) + 1'b1))
        else $error("Counter mode missed a sampled edge.");

    // Rollover sets the flag on the next edge.
    rollover_flag_a: assert property (
        inc_go && (&tmr_q) |=> flag_q && tmr_q == '0)
        else $error("Rollover did not set the overflow flag.");

    // With the enable low the interrupt stays low.
    irq_mask_a: assert property (
        !ie_q [*2] |-> !o_irq)
        else $error("Interrupt raised while masked.");

    // A set flag with enable high reaches the output next cycle.
    irq_raise_a: assert property (
        flag_q && ie_q |=> o_irq)
        else $error("Enabled flag did not raise the interrupt.");

    // The flag never drops without a software clear.
    flag_sticky_a: assert property (
        flag_q && !(wr_ictl && i_wdata[tz_pkg::ICTL_IF_BIT]) |=> flag_q)
        else $error("Overflow flag dropped by itself.");

    // Sleep freezes the timer.
    sleep_hold_a: assert property (
        i_sleep && !wr_tmr |=> $stable(tmr_q))
        else $error("Timer moved during sleep.");

    // The phase-two sample changes only after phase two.
    sample_phase_a: assert property (
        $changed(samp2_q) |-> $past(q2_en))
        else $error("Prescaler sample taken outside phase two.");

    // Timer writes clear a timer-owned prescaler.
    tmr_clr_a: assert property (
        wr_tmr && !prescaler_assign |=> pre_cnt == '0)
        else $error("Timer write left the prescaler counting.");

    // Watchdog clear clears a watchdog-owned prescaler.
    wdt_clr_a: assert property (
        i_wdt_clear && prescaler_assign |=> pre_cnt == '0)
        else $error("Watchdog clear left the prescaler counting.");

    // Ratio 1:1 passes every watchdog tick.
    wdt_pass_a: assert property (
        prescaler_assign && rs == '0 && i_wdt_tick && !i_wdt_clear |=> o_wdt_post)
        else $error("Watchdog tick not passed at ratio 1:1.");

endmodule : tz_timer

// >>> include/tz_pkg.sv
// Shared constants and types of the timer/counter with shared prescaler.
package tz_pkg;

    // Register port widths.
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // Register addresses on the register port.
    localparam logic [7:0] ADDR_TMR     = 8'h01;
    localparam logic [7:0] ADDR_ICTL    = 8'h0b;
    localparam logic [7:0] ADDR_ICTL_HI = 8'h8b;
    localparam logic [7:0] ADDR_OPT     = 8'h81;

    // Field positions in interrupt_control.
    localparam int ICTL_IE_BIT = 5;
    localparam int ICTL_IF_BIT = 2;

    // Field positions in option_config.
    localparam int OPT_CS_BIT  = 5;
    localparam int OPT_SE_BIT  = 4;
    localparam int OPT_PSA_BIT = 3;
    localparam int OPT_RS_LSB  = 0;
    localparam int RS_W        = 3;

    // Reset values.
    localparam logic [7:0] RST_OPT  = 8'hff;
    localparam logic [7:0] RST_TMR  = 8'h00;
    localparam logic [7:0] RST_RD   = 8'h00;

    // Increments skipped after a timer register write, in instruction cycles.
    localparam logic [1:0] INHIB_CYC = 2'h2;

    // Core clock rate; four core clocks form one instruction cycle.
    localparam int CLK_HZ = 10_000_000;

    // Internal phase clocks of one instruction cycle.
    typedef enum logic [1:0] {
        TZ_Q1,
        TZ_Q2,
        TZ_Q3,
        TZ_Q4
    } tz_phase_e;

endpackage : tz_pkg

// >>> verilog/tz_prescaler.sv
// Shared eight-bit prescaler counter, hidden from software.
`timescale 1ns/10ps
module tz_prescaler #(
    parameter int P_W = 8
) (
    input  wire logic           i_clk,
    input  wire logic           i_rst,
    input  wire logic           i_clr,
    input  wire logic           i_en,
    output logic [P_W-1:0]      o_count
);

    // A one-bit counter could serve no division ratio but 1:2.
    if (P_W < 2) begin : g_bad_width
        $error("tz_prescaler: P_W must be at least 2.");
    end

    // Counter state; the owner taps one bit of it as its divided output.
    logic [P_W-1:0] cnt_q;

    // Clear beats count, so a clear in the counting cycle leaves zero.
    // The count has no register address: nothing reads or writes it.
    always_ff @(posedge i_clk) begin
        if (i_rst || i_clr) begin
            cnt_q <= '0;
        end else if (i_en) begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    // Count goes out straight from the register.
    assign o_count = cnt_q;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    // A clear leaves the counter at zero on the next edge.
    presc_clear_a: assert property (i_clr |=> cnt_q == '0)
        else $error("Prescaler not zero after clear.");

endmodule : tz_prescaler

// >>> verif/tz_far_side.sv
// Far-side model: count pin source and watchdog time base.
`timescale 1ns/10ps
module tz_far_side (
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic        i_go,
    input  wire logic        i_kind,
    input  wire logic [15:0] i_n,
    input  wire logic [3:0]  i_half,
    output logic             o_pin,
    output logic             o_tick,
    output logic             o_busy
);
    logic [16:0] left_q; // Steps still to make.
    logic [3:0]  cnt_q;  // Cycles spent in this step.
    logic        kind_q; // High for a burst of watchdog ticks.
    logic [3:0]  span;   // Last cycle of one step.

    // Pin levels last four clocks or more, above the sampling need.
    assign span   = kind_q ? 4'h7 : (i_half - 4'h1);
    assign o_busy = (left_q != 17'h0_0000);

    // Each step ends in one tick or one pin toggle; a pin burst toggles
    // an even number of times, so the pin rests low between bursts.
    always_ff @(posedge i_clk) begin
        o_tick <= !i_rst && !i_go && o_busy && cnt_q == span && kind_q;
        if (i_rst) begin
            left_q <= 17'h0_0000;
            cnt_q  <= 4'h0;
            kind_q <= 1'b0;
            o_pin  <= 1'b0;
        end else if (i_go) begin
            left_q <= i_kind ? {1'b0, i_n} : {i_n, 1'b0};
            kind_q <= i_kind;
            cnt_q  <= 4'h0;
        end else if (o_busy && cnt_q == span) begin
            cnt_q  <= 4'h0;
            left_q <= left_q - 17'h0_0001;
            o_pin  <= o_pin ^ !kind_q;
        end else if (o_busy) begin
            cnt_q <= cnt_q + 4'h1;
        end
    end
endmodule : tz_far_side

// >>> verif/tb_top.sv
// Self-checking bench of the timer/counter with shared prescaler.
`timescale 1ns/10ps
module tb_top;
    logic        i_clk;       // Core clock, 100 ns period.
    logic        i_rst;       // Synchronous reset, active high.
    logic [7:0]  i_addr;      // Register address.
    logic [7:0]  i_wdata;     // Register write data.
    logic        i_wr;        // Write strobe.
    logic        i_rd;        // Read strobe.
    logic [7:0]  o_rdata;     // Read data.
    logic        i_sleep;     // Sleep level.
    logic        i_wdt_clear; // Watchdog clear instruction.
    logic        o_wdt_post;  // Postscaled watchdog tick.
    logic        o_irq;       // Overflow interrupt.
    logic        pin;         // Count pin from the far side.
    logic        tick;        // Watchdog time-base tick.
    logic        f_go;        // Starts a far-side burst.
    logic        f_kind;      // Ticks when high, pin pulses when low.
    logic [15:0] f_n;         // Length of the burst.
    logic [3:0]  f_half;      // Pin half period in clocks.
    logic        f_busy;      // Far side still sending.
    logic [31:0] seed;        // Xorshift state.
    logic [7:0]  v;           // Last value read.
    logic [7:0]  t;           // Value written to the timer.
    logic [7:0]  e;           // Expected value.
    int          n_fail;      // Mismatches.
    int          checked;     // Comparisons.
    int          cyc;         // Cycles since release; phase is cyc % 4.
    int          n_post;      // Postscaled ticks seen.
    int          w_cyc;       // Cycle of the last write strobe.
    int          r_cyc;       // Cycle of the last read strobe.
    int          np;          // Tick count before a burst.
    int          tt;          // Ticks in a burst.

    initial i_clk = 1'b0;
    always #50 i_clk = ~i_clk;

    // Cycle index restarts at zero in the first cycle after release.
    always @(posedge i_clk) begin
        cyc <= i_rst ? 0 : cyc + 1;
        if (o_wdt_post === 1'b1) begin
            n_post <= n_post + 1;
        end
    end

    tz_timer i_dut (
        .i_clk       (i_clk),
        .i_rst       (i_rst),
        .i_addr      (i_addr),
        .i_wdata     (i_wdata),
        .i_wr        (i_wr),
        .i_rd        (i_rd),
        .o_rdata     (o_rdata),
        .i_ext_clk   (pin),
        .i_sleep     (i_sleep),
        .i_wdt_tick  (tick),
        .i_wdt_clear (i_wdt_clear),
        .o_wdt_post  (o_wdt_post),
        .o_irq       (o_irq)
    );

    tz_far_side i_far (
        .i_clk  (i_clk),
        .i_rst  (i_rst),
        .i_go   (f_go),
        .i_kind (f_kind),
        .i_n    (f_n),
        .i_half (f_half),
        .o_pin  (pin),
        .o_tick (tick),
        .o_busy (f_busy)
    );

    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction : rnd

    // Undivided timer: one step per Q4 edge after the write, less the
    // two inhibited ones; the read sees the value before its own edge.
    function automatic logic [7:0] tmr_exp(input logic [7:0] t0,
                                           input int w, input int r);
        int k;
        k = 0;
        for (int q = w + 1; q < r; q++) begin
            if (q % 4 == 3) k++;
        end
        k = (k > 2) ? k - 2 : 0;
        return t0 + 8'(k);
    endfunction : tmr_exp

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic tally_and_finish();
        $display("checked=%0d n_fail=%0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : tally_and_finish

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        w_cyc = cyc + 1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask : wr

    // Read data stands only in the cycle after the strobe.
    task automatic rd(input logic [7:0] a);
        @(posedge i_clk);
        i_rd   <= 1'b1;
        i_addr <= a;
        r_cyc = cyc + 1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        @(negedge i_clk);
        v = o_rdata;
    endtask : rd

    task automatic clr_wdt();
        @(posedge i_clk);
        i_wdt_clear <= 1'b1;
        @(posedge i_clk);
        i_wdt_clear <= 1'b0;
    endtask : clr_wdt

    // A bounded wait covers the burst; a hang ends the run.
    task automatic burst(input logic k, input int n);
        @(posedge i_clk);
        f_go   <= 1'b1;
        f_kind <= k;
        f_n    <= 16'(n);
        f_half <= 4'h4 + 4'(rnd() % 8'h04);
        @(posedge i_clk);
        f_go <= 1'b0;
        for (int i = 0; i <= 20000; i++) begin
            @(posedge i_clk);
            if (f_busy !== 1'b1) break;
            if (i == 20000) begin
                n_fail++;
                tally_and_finish();
            end
        end
        repeat (12) @(posedge i_clk);
    endtask : burst

    initial begin
        seed = 32'h0000_001f;
        n_fail = 0;
        checked = 0;
        n_post = 0;
        cyc = 0;
        i_rst = 1'b1;
        i_addr = 8'h00;
        i_wdata = 8'h00;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_sleep = 1'b0;
        i_wdt_clear = 1'b0;
        f_go = 1'b0;
        f_kind = 1'b0;
        f_n = 16'h0000;
        f_half = 4'h4;
        repeat (6) @(posedge i_clk);
        i_rst <= 1'b0;
        // Reset values, then an unmapped place that ignores writes.
        rd(tz_pkg::ADDR_OPT);
        chk(v, 8'hff);
        rd(tz_pkg::ADDR_ICTL);
        chk(v, 8'h00);
        rd(tz_pkg::ADDR_TMR);
        chk(v, 8'h00);
        wr(8'h05, rnd());
        rd(8'h05);
        chk(v, 8'h00);
        @(negedge i_clk);
        chk(o_rdata, 8'h00);
        for (int i = 0; i < 4; i++) begin
            t = rnd();
            wr(tz_pkg::ADDR_OPT, t);
            rd(tz_pkg::ADDR_OPT);
            chk(v, t);
        end
        // Timer mode with the prescaler on the watchdog: undivided.
        wr(tz_pkg::ADDR_OPT, 8'h08);
        for (int i = 0; i < 6; i++) begin
            t = rnd();
            wr(tz_pkg::ADDR_TMR, t);
            np = w_cyc;
            repeat (int'(rnd() % 8'd40)) @(posedge i_clk);
            rd(tz_pkg::ADDR_TMR);
            chk(v, tmr_exp(t, np, r_cyc));
        end
        // Overflow while masked, then unmasked after the flag is cleared.
        wr(tz_pkg::ADDR_ICTL, 8'h04);
        wr(tz_pkg::ADDR_TMR, 8'hfe);
        repeat (24) @(posedge i_clk);
        rd(tz_pkg::ADDR_ICTL);
        chk(v, 8'h04);
        chk({7'h00, o_irq}, 8'h00);
        wr(tz_pkg::ADDR_ICTL_HI, 8'h04);
        rd(tz_pkg::ADDR_ICTL);
        chk(v, 8'h00);
        wr(tz_pkg::ADDR_ICTL, 8'h20);
        wr(tz_pkg::ADDR_TMR, 8'hfe);
        repeat (24) @(posedge i_clk);
        rd(tz_pkg::ADDR_ICTL_HI);
        chk(v, 8'h24);
        chk({7'h00, o_irq}, 8'h01);
        wr(tz_pkg::ADDR_ICTL, 8'h24);
        repeat (3) @(posedge i_clk);
        chk({7'h00, o_irq}, 8'h00);
        // Sleep freezes the timer, so no overflow can come.
        i_sleep <= 1'b1;
        wr(tz_pkg::ADDR_TMR, 8'hfe);
        repeat (40) @(posedge i_clk);
        rd(tz_pkg::ADDR_TMR);
        chk(v, 8'hfe);
        chk({7'h00, o_irq}, 8'h00);
        @(posedge i_clk);
        i_sleep <= 1'b0;
        wr(tz_pkg::ADDR_ICTL, 8'h00);
        // Pin counting on each edge choice, undivided.
        for (int se = 0; se < 2; se++) begin
            wr(tz_pkg::ADDR_OPT, 8'h28 | 8'(se << 4));
            wr(tz_pkg::ADDR_TMR, 8'h00);
            repeat (16) @(posedge i_clk);
            tt = 3 + int'(rnd() % 8'h08);
            burst(1'b0, tt);
            rd(tz_pkg::ADDR_TMR);
            chk(v, 8'(tt));
        end
        // Every timer rate; the left-over count must not survive a write.
        for (int rs = 0; rs < 8; rs++) begin
            clr_wdt();
            wr(tz_pkg::ADDR_OPT, 8'h20 | 8'(rs));
            burst(1'b0, (2 << rs) - 1);
            wr(tz_pkg::ADDR_TMR, 8'h00);
            repeat (16) @(posedge i_clk);
            burst(1'b0, 3 << rs);
            e = 8'(((3 << rs) + (1 << rs)) / (2 << rs));
            rd(tz_pkg::ADDR_TMR);
            chk(v, e);
        end
        clr_wdt();
        wr(tz_pkg::ADDR_TMR, 8'h00);
        wr(tz_pkg::ADDR_OPT, 8'h2f);
        clr_wdt();
        // Every watchdog rate; a clear drops the left-over count.
        for (int rs = 0; rs < 8; rs++) begin
            wr(tz_pkg::ADDR_OPT, 8'h08 | 8'(rs));
            burst(1'b1, (1 << rs) - 1);
            clr_wdt();
            repeat (4) @(posedge i_clk);
            np = n_post;
            tt = (rs == 0) ? 3 : (3 << (rs - 1));
            e = (rs == 0) ? 8'h03 : 8'((tt + (1 << (rs - 1))) >> rs);
            burst(1'b1, tt);
            chk(8'(n_post - np), e);
        end
        tally_and_finish();
    end
endmodule : tb_top
